/* core/pxc_pkg.sv */
// ---------------------------------------------------------------
// shared constants of the extended control block
// ---------------------------------------------------------------
package pxc_pkg;
	// register map
	localparam logic [4:0] EXT_CTRL_ADDR = 5'h10; // extended control register
	// field positions
	localparam int COWE_BIT = 15; // one-shot override write enable
	localparam int ADDR_MSB = 10; // management address, top bit
	localparam int ADDR_LSB = 6; // management address, bottom bit
	localparam int TEST_BIT = 5; // cipher test, forces lock loss
	localparam int NRZI_BIT = 3; // line coding select
	localparam int INV_BIT = 2; // invalid code transmit
	localparam int OFF_BIT = 0; // cipher bypass
	localparam logic [15:0] RESV_MASK = 16'h7812; // reserved bits, read zero
	// reset values
	localparam logic COWE_RST = 1'h0; // override write off
	localparam logic TEST_RST = 1'h0; // normal operation
	localparam logic NRZI_RST = 1'h1; // nrzi coding
	localparam logic INV_RST = 1'h0; // standard translation
	localparam logic OFF_RST = 1'h0; // cipher active
	// data path widths and counts
	localparam int NIB_W = 4; // mii nibble
	localparam int CODE_W = 5; // line symbol
	localparam int LFSR_W = 11; // cipher register
	localparam logic [2:0] SYM_LAST = 3'h4; // last bit index of a symbol
	localparam logic [5:0] LOCK_RUN = 6'h1e; // matched idle bits before lock
	localparam logic [10:0] LFSR_SEED = 11'h7ff; // nonzero cipher seed
	localparam logic [4:0] IDLE_CODE = 5'h1f; // idle symbol
	// standard 4b/5b translation
	localparam logic [4:0] STD_CODE [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
	// invalid code test translation
	localparam logic [4:0] INV_CODE [16] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
		5'h00, 5'h0d, 5'h0c, 5'h11, 5'h10, 5'h19, 5'h18, 5'h1f};
endpackage

/* core/pxc_stream_if.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------
// valid/ready symbol stream between encoder, buffer and serialiser
// ---------------------------------------------------------------
interface pxc_stream_if;
	logic valid; // word offered
	logic ready; // word accepted
	logic [pxc_pkg::CODE_W-1:0] data; // line symbol
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

/* core/pxc_buf2.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------
// two-entry symbol buffer, link clock domain
// ---------------------------------------------------------------
module pxc_buf2 (
	input wire logic clk, // link clock
	input wire logic rstN, // synchronised link reset
	pxc_stream_if.snk fill, // from encoder
	pxc_stream_if.src drain // to serialiser
);
	logic [pxc_pkg::CODE_W-1:0] mem_r [2]; // storage
	logic wrPtr_r; // next entry written
	logic rdPtr_r; // next entry read
	logic [1:0] count_r; // entries held
	logic push; // accepted on fill side
	logic pop; // taken on drain side

	assign fill.ready = (count_r != 2'h2); // honest full
	assign drain.valid = (count_r != 2'h0); // honest empty
	assign drain.data = mem_r[rdPtr_r]; // registered entry
	assign push = fill.valid & fill.ready;
	assign pop = drain.valid & drain.ready;

	// storage write
	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem_r[wrPtr_r] <= fill.data;
		end
	end

	// pointers and fill level
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			wrPtr_r <= 1'h0;
			rdPtr_r <= 1'h0;
			count_r <= 2'h0;
		end
		else
		begin
			if (push)
				wrPtr_r <= ~wrPtr_r;
			if (pop)
				rdPtr_r <= ~rdPtr_r;
			count_r <= count_r + {1'h0, push} - {1'h0, pop};
		end
	end
endmodule

/* core/pxc_ext_ctrl.sv */
`timescale 1ns/10ps
module pxc_ext_ctrl (
	input wire logic ref_clk, // management clock, 100 mhz
	input wire logic rst_n, // hardware or power-on reset
	input wire logic swRst, // software reset pulse
	input wire logic [4:0] ledAddrPin, // addr4_led_pin..addr0_led_pin
	input wire logic [4:0] regAddr, // management register address
	input wire logic [15:0] regWrData, // management write data
	input wire logic regWrEn, // management write strobe
	input wire logic regRdEn, // management read strobe
	output logic [15:0] regRdData, // read data
	output logic regRdValid, // read data strobe
	output logic ovrGrant, // write may alter protected bits
	output logic [4:0] ovrGrantAddr, // register that grant applies to
	output logic [4:0] phyAddr, // latched management address
	input wire logic speed100, // fast mode selected
	input wire logic linkClk, // transmit link clock
	input wire logic [3:0] txNib, // mii transmit nibble
	input wire logic txErr, // mii transmit error
	input wire logic nibValid, // nibble offered
	output logic nibReady, // nibble accepted
	output logic txSer, // serial line bit
	input wire logic rxSer, // serial receive bit
	output logic rxPlain, // descrambled receive bit
	output logic rxLocked // descrambler locked
);
	// ---------------------------------------------------------------
	// management domain
	// ---------------------------------------------------------------
	logic [4:0] pinMeta_r; // led pin sync, first stage
	logic [4:0] pinSync_r; // led pin sync, second stage
	logic strapped_r; // address captured since reset
	logic [4:0] addr_r; // latched address
	logic cowe_r; // override write enable
	logic test_r; // cipher test mode
	logic nrzi_r; // nrzi select
	logic inv_r; // invalid code transmit
	logic off_r; // cipher bypass
	logic [15:0] rdData_r; // read data register
	logic rdValid_r; // read strobe register
	logic grant_r; // grant pulse register
	logic [4:0] grantAddr_r; // granted register
	logic hitWr; // write to this register
	logic [15:0] regImage; // current register contents

	assign hitWr = regWrEn & (regAddr == pxc_pkg::EXT_CTRL_ADDR);

	// register image, reserved bits forced low
	always_comb
	begin
		regImage = 16'h0000;
		regImage[pxc_pkg::COWE_BIT] = cowe_r;
		regImage[pxc_pkg::ADDR_MSB:pxc_pkg::ADDR_LSB] = addr_r;
		regImage[pxc_pkg::TEST_BIT] = test_r;
		regImage[pxc_pkg::NRZI_BIT] = nrzi_r;
		regImage[pxc_pkg::INV_BIT] = inv_r;
		regImage[pxc_pkg::OFF_BIT] = off_r;
		regImage = regImage & ~pxc_pkg::RESV_MASK;
	end

	// led pin synchroniser, free running so it is valid at release
	always_ff @(posedge ref_clk)
	begin
		pinMeta_r <= ledAddrPin;
		pinSync_r <= pinMeta_r;
	end

	// address strap, caught on the first edge after reset release
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			strapped_r <= 1'h0;
			addr_r <= 5'h00;
		end
		else if (!strapped_r)
		begin
			strapped_r <= 1'h1;
			addr_r <= pinSync_r;
		end
		// software reset and writes leave the address alone
	end

	// one-shot override write enable
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			cowe_r <= pxc_pkg::COWE_RST;
		else if (swRst)
			cowe_r <= pxc_pkg::COWE_RST;
		else if (hitWr)
			cowe_r <= regWrData[pxc_pkg::COWE_BIT];
		else if (regWrEn)
			cowe_r <= 1'h0;
	end

	// grant to the register targeted by the next write
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			grant_r <= 1'h0;
			grantAddr_r <= 5'h00;
		end
		else
		begin
			grant_r <= regWrEn & cowe_r & ~swRst;
			if (regWrEn & cowe_r)
				grantAddr_r <= regAddr;
		end
	end

	// read-write control bits; reserved write data is dropped
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			test_r <= pxc_pkg::TEST_RST;
			nrzi_r <= pxc_pkg::NRZI_RST;
			inv_r <= pxc_pkg::INV_RST;
			off_r <= pxc_pkg::OFF_RST;
		end
		else if (swRst)
		begin
			test_r <= pxc_pkg::TEST_RST;
			nrzi_r <= pxc_pkg::NRZI_RST;
			inv_r <= pxc_pkg::INV_RST;
			off_r <= pxc_pkg::OFF_RST;
		end
		else if (hitWr)
		begin
			test_r <= regWrData[pxc_pkg::TEST_BIT];
			nrzi_r <= regWrData[pxc_pkg::NRZI_BIT];
			inv_r <= regWrData[pxc_pkg::INV_BIT];
			off_r <= regWrData[pxc_pkg::OFF_BIT];
		end
	end

	// read port, one cycle after the strobe
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdData_r <= 16'h0000;
			rdValid_r <= 1'h0;
		end
		else
		begin
			rdValid_r <= regRdEn;
			if (regRdEn)
				rdData_r <= (regAddr == pxc_pkg::EXT_CTRL_ADDR) ? regImage : 16'h0000;
		end
	end

	assign regRdData = rdData_r;
	assign regRdValid = rdValid_r;
	assign ovrGrant = grant_r;
	assign ovrGrantAddr = grantAddr_r;
	assign phyAddr = addr_r;

	// ---------------------------------------------------------------
	// link domain: reset, control crossing
	// ---------------------------------------------------------------
	logic linkRstMeta_r; // reset release, first stage
	logic linkRstN_r; // synchronised link reset
	logic [4:0] ctlMeta_r; // control sync, first stage
	logic [4:0] ctlSync_r; // control sync: speed, test, nrzi, inv, off
	logic fastOn; // fast mode in link domain
	logic testOn; // cipher test in link domain
	logic nrziOn; // nrzi in link domain
	logic invOn; // invalid map in link domain
	logic cipherOn; // scrambler active

	// reset asserts at once, releases on the link clock
	always_ff @(posedge linkClk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			linkRstMeta_r <= 1'h0;
			linkRstN_r <= 1'h0;
		end
		else
		begin
			linkRstMeta_r <= 1'h1;
			linkRstN_r <= linkRstMeta_r;
		end
	end

	// level crossing of the control bits and the speed pin
	always_ff @(posedge linkClk or negedge linkRstN_r)
	begin
		if (!linkRstN_r)
		begin
			ctlMeta_r <= {1'h0, pxc_pkg::TEST_RST, pxc_pkg::NRZI_RST, pxc_pkg::INV_RST, pxc_pkg::OFF_RST};
			ctlSync_r <= {1'h0, pxc_pkg::TEST_RST, pxc_pkg::NRZI_RST, pxc_pkg::INV_RST, pxc_pkg::OFF_RST};
		end
		else
		begin
			ctlMeta_r <= {speed100, test_r, nrzi_r, inv_r, off_r};
			ctlSync_r <= ctlMeta_r;
		end
	end

	assign fastOn = ctlSync_r[4];
	assign testOn = ctlSync_r[3];
	assign nrziOn = ctlSync_r[2];
	assign invOn = ctlSync_r[1];
	assign cipherOn = fastOn & ~ctlSync_r[0];

	// ---------------------------------------------------------------
	// link domain: encoder and buffer
	// ---------------------------------------------------------------
	pxc_stream_if fillIf (); // encoder to buffer
	pxc_stream_if drainIf (); // buffer to serialiser

	// nibble translation, invalid map only on error
	always_comb
	begin
		if (invOn & txErr)
			fillIf.data = pxc_pkg::INV_CODE[txNib];
		else
			fillIf.data = pxc_pkg::STD_CODE[txNib];
	end

	assign fillIf.valid = nibValid;
	assign nibReady = fillIf.ready;

	pxc_buf2 u_pxc_buf2 (
		.clk(linkClk),
		.rstN(linkRstN_r),
		.fill(fillIf),
		.drain(drainIf)
	);

	// ---------------------------------------------------------------
	// link domain: serialiser, scrambler, line coding
	// ---------------------------------------------------------------
	logic [4:0] shift_r; // symbol being sent
	logic [2:0] bitCnt_r; // bit index in symbol
	logic [10:0] txLfsr_r; // transmit cipher
	logic txKey; // cipher stream bit
	logic lineBit; // bit after cipher
	logic txSer_r; // line output register
	logic symLoad; // next symbol loads

	assign symLoad = (bitCnt_r == pxc_pkg::SYM_LAST);
	assign drainIf.ready = symLoad;
	assign txKey = txLfsr_r[10] ^ txLfsr_r[8];
	assign lineBit = cipherOn ? (shift_r[4] ^ txKey) : shift_r[4];

	// symbol shifter, idle when the buffer is empty
	always_ff @(posedge linkClk or negedge linkRstN_r)
	begin
		if (!linkRstN_r)
		begin
			shift_r <= pxc_pkg::IDLE_CODE;
			bitCnt_r <= 3'h0;
		end
		else if (symLoad)
		begin
			shift_r <= drainIf.valid ? drainIf.data : pxc_pkg::IDLE_CODE;
			bitCnt_r <= 3'h0;
		end
		else
		begin
			shift_r <= {shift_r[3:0], 1'h0};
			bitCnt_r <= bitCnt_r + 3'h1;
		end
	end

	// transmit cipher advances only while in use
	always_ff @(posedge linkClk or negedge linkRstN_r)
	begin
		if (!linkRstN_r)
			txLfsr_r <= pxc_pkg::LFSR_SEED;
		else if (cipherOn)
			txLfsr_r <= {txLfsr_r[9:0], txKey};
	end

	// nrz passes the bit, nrzi toggles on one in fast mode
	always_ff @(posedge linkClk or negedge linkRstN_r)
	begin
		if (!linkRstN_r)
			txSer_r <= 1'h0;
		else if (fastOn & nrziOn)
			txSer_r <= txSer_r ^ lineBit;
		else
			txSer_r <= lineBit;
	end

	assign txSer = txSer_r;

	// ---------------------------------------------------------------
	// link domain: receive descrambler and lock
	// ---------------------------------------------------------------
	logic [10:0] rxLfsr_r; // receive cipher
	logic [5:0] runCnt_r; // matched idle bits
	logic locked_r; // descrambler lock
	logic rxPlain_r; // receive output register
	logic rxKey; // predicted cipher bit

	assign rxKey = rxLfsr_r[10] ^ rxLfsr_r[8];

	// lock search on idle: key equals inverted line bit
	always_ff @(posedge linkClk or negedge linkRstN_r)
	begin
		if (!linkRstN_r)
		begin
			rxLfsr_r <= pxc_pkg::LFSR_SEED;
			runCnt_r <= 6'h00;
			locked_r <= 1'h0;
		end
		else if (testOn | ~cipherOn)
		begin
			runCnt_r <= 6'h00;
			locked_r <= 1'h0;
		end
		else if (locked_r)
			rxLfsr_r <= {rxLfsr_r[9:0], rxKey};
		else
		begin
			rxLfsr_r <= {rxLfsr_r[9:0], ~rxSer};
			if (rxKey != ~rxSer)
				runCnt_r <= 6'h00;
			else if (runCnt_r == pxc_pkg::LOCK_RUN)
				locked_r <= 1'h1;
			else
				runCnt_r <= runCnt_r + 6'h01;
		end
	end

	// descrambled output, raw when bypassed
	always_ff @(posedge linkClk or negedge linkRstN_r)
	begin
		if (!linkRstN_r)
			rxPlain_r <= 1'h0;
		else if (cipherOn)
			rxPlain_r <= rxSer ^ rxKey;
		else
			rxPlain_r <= rxSer;
	end

	assign rxPlain = rxPlain_r;
	assign rxLocked = locked_r;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_plainWrite;
		regWrEn && !swRst && !(hitWr && regWrData[pxc_pkg::COWE_BIT]);
	endsequence
	property p_coweClear;
		@(posedge ref_clk) disable iff (!rst_n) s_plainWrite |=> !cowe_r;
	endproperty
	a_coweClear: assert property (p_coweClear) else $error("override enable not cleared");
	property p_grant;
		@(posedge ref_clk) disable iff (!rst_n)
			(regWrEn && cowe_r && !swRst) |=> (ovrGrant && ovrGrantAddr == $past(regAddr))
			##1 (!ovrGrant || ($past(regWrEn) && $past(cowe_r)));
	endproperty
	a_grant: assert property (p_grant) else $error("grant wrong");
	property p_resvZero;
		@(posedge ref_clk) disable iff (!rst_n) regRdValid |-> (regRdData & pxc_pkg::RESV_MASK) == 16'h0000;
	endproperty
	a_resvZero: assert property (p_resvZero) else $error("reserved bit read high");
	property p_addrRead;
		@(posedge ref_clk) disable iff (!rst_n)
			(regRdEn && regAddr == pxc_pkg::EXT_CTRL_ADDR) |=> regRdData[10:6] == phyAddr;
	endproperty
	a_addrRead: assert property (p_addrRead) else $error("address field wrong");
	property p_strap;
		@(posedge ref_clk) disable iff (!rst_n) !strapped_r |=> phyAddr == $past(pinSync_r);
	endproperty
	a_strap: assert property (p_strap) else $error("address not latched");
	property p_addrHold;
		@(posedge ref_clk) disable iff (!rst_n) strapped_r |=> $stable(phyAddr);
	endproperty
	a_addrHold: assert property (p_addrHold) else $error("address changed");
	property p_swDefault;
		@(posedge ref_clk) disable iff (!rst_n) swRst |=> nrzi_r && !cowe_r && !inv_r;
	endproperty
	a_swDefault: assert property (p_swDefault) else $error("software reset defaults");
	property p_testUnlock;
		@(posedge linkClk) disable iff (!linkRstN_r) testOn |=> !rxLocked;
	endproperty
	a_testUnlock: assert property (p_testUnlock) else $error("lock held in test");
	property p_bypass;
		@(posedge linkClk) disable iff (!linkRstN_r) !cipherOn |=> rxPlain == $past(rxSer) && $stable(txLfsr_r);
	endproperty
	a_bypass: assert property (p_bypass) else $error("cipher not bypassed");
	property p_invMap;
		@(posedge linkClk) disable iff (!linkRstN_r)
			(nibValid && nibReady && invOn && txErr && txNib == 4'h8) |-> fillIf.data == 5'h00;
	endproperty
	a_invMap: assert property (p_invMap) else $error("invalid map wrong");
endmodule

/* tb/pxc_sta_model.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------
// management entity model, drives the register port
// ---------------------------------------------------------------
module pxc_sta_model (
	input wire logic ref_clk, // management clock
	output logic [4:0] regAddr, // register address
	output logic [15:0] regWrData, // write data
	output logic regWrEn, // write strobe
	output logic regRdEn, // read strobe
	input wire logic [15:0] regRdData, // read data
	input wire logic regRdValid, // read data strobe
	input wire logic ovrGrant, // protected write granted
	input wire logic [4:0] ovrGrantAddr // granted register
);
	// idle request lines from time zero
	initial
	begin
		regAddr = 5'h00;
		regWrData = 16'h0000;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
	end

	// one write, reserved bits of this register kept at zero default
	task automatic wr(input logic [4:0] a, input logic [15:0] d, output logic g, output logic [4:0] ga);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= (a == pxc_pkg::EXT_CTRL_ADDR) ? (d & ~pxc_pkg::RESV_MASK) : d;
		regWrEn <= 1'b1;
		@(posedge ref_clk);
		regWrEn <= 1'b0;
		#1;
		g = ovrGrant;
		ga = ovrGrantAddr;
	endtask

	// one read, answer taken one cycle after the strobe
	task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic v);
		@(posedge ref_clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge ref_clk);
		regRdEn <= 1'b0;
		#1;
		v = regRdValid;
		d = regRdData;
	endtask
endmodule

/* tb/tb_phy_extended_control.sv */
`timescale 1ns/10ps
module tb_phy_extended_control;
	// ---------------------------------------------------------------
	// stimulus and observed signals
	// ---------------------------------------------------------------
	localparam logic [4:0] INV_EXP [16] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
		5'h00, 5'h0d, 5'h0c, 5'h11, 5'h10, 5'h19, 5'h18, 5'h1f}; // expected error-test symbols
	localparam logic [4:0] CA = pxc_pkg::EXT_CTRL_ADDR; // register under test
	logic ref_clk = 1'b0; // management clock
	logic linkClk = 1'b0; // link clock
	logic rst_n = 1'b0; // hardware reset
	logic swRst = 1'b0; // software reset
	logic [4:0] ledAddrPin = 5'h15; // address straps
	logic speed100 = 1'b0; // fast mode
	logic [3:0] txNib = 4'h0; // nibble
	logic txErr = 1'b0; // transmit error
	logic nibValid = 1'b0; // nibble offered
	logic rxSer = 1'b1; // loopback receive bit
	logic [4:0] regAddr, ovrGrantAddr, phyAddr;
	logic [15:0] regWrData, regRdData;
	logic regWrEn, regRdEn, regRdValid, ovrGrant, nibReady, txSer, rxPlain, rxLocked;
	int n_fail = 0; // mismatches
	int n_tests = 0; // comparisons

	always #5 ref_clk = ~ref_clk;
	// link clock, offset phase
	initial
	begin
		#3.3;
		forever #62.5 linkClk = ~linkClk;
	end
	// transmit looped into receive
	always @(posedge linkClk) rxSer <= txSer;

	pxc_ext_ctrl u_pxc_ext_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .swRst(swRst), .ledAddrPin(ledAddrPin),
		.regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
		.regRdValid(regRdValid), .ovrGrant(ovrGrant), .ovrGrantAddr(ovrGrantAddr), .phyAddr(phyAddr),
		.speed100(speed100), .linkClk(linkClk), .txNib(txNib), .txErr(txErr), .nibValid(nibValid),
		.nibReady(nibReady), .txSer(txSer), .rxSer(rxSer), .rxPlain(rxPlain), .rxLocked(rxLocked));
	pxc_sta_model u_pxc_sta_model (.ref_clk(ref_clk), .regAddr(regAddr), .regWrData(regWrData),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
		.ovrGrant(ovrGrant), .ovrGrantAddr(ovrGrantAddr));

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict;
		$display("comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// expected register image
	function automatic logic [31:0] ctl(input logic [4:0] a, input int b15, b5, b3, b2, b0);
		ctl = {16'h0, b15[0], 4'h0, a, b5[0], 1'b0, b3[0], b2[0], 1'b0, b0[0]};
	endfunction

	// idle ones with one symbol somewhere inside
	function automatic logic fits(input logic [23:0] h, input logic [4:0] c);
		logic [23:0] e;
		fits = 1'b0;
		for (int o = 0; o < 20; o++)
		begin
			e = '1;
			e[o+:5] = c;
			if (h === e)
				fits = 1'b1;
		end
	endfunction

	task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
		logic [15:0] d;
		logic v;
		u_pxc_sta_model.rd(a, d, v);
		check({31'h0, v}, 32'h1);
		check({16'h0, d}, exp);
	endtask

	task automatic wrc(input logic [4:0] a, input logic [15:0] d, input logic eg);
		logic g;
		logic [4:0] ga;
		u_pxc_sta_model.wr(a, d, g, ga);
		check({31'h0, g}, {31'h0, eg});
		if (eg)
			check({27'h0, ga}, {27'h0, a});
		repeat (4) @(posedge linkClk); // let control bits reach the link side
	endtask

	task automatic grab(input int n, output logic [23:0] h);
		h = '0;
		repeat (n)
		begin
			@(posedge linkClk);
			#1;
			h = {h[22:0], txSer};
		end
	endtask

	// offer one nibble, then look for its symbol on the line
	task automatic send(input logic [3:0] n, input logic e, input logic [4:0] c);
		logic [23:0] h;
		@(posedge linkClk);
		txNib <= n;
		txErr <= e;
		nibValid <= 1'b1;
		#1;
		while (nibReady !== 1'b1)
		begin
			@(posedge linkClk);
			#1;
		end
		@(posedge linkClk);
		nibValid <= 1'b0;
		grab(24, h);
		check({31'h0, fits(h, c)}, 32'h1);
	endtask

	task automatic waitLock(input logic lv, input int lim);
		int k;
		k = 0;
		while (rxLocked !== lv && k < lim)
		begin
			@(posedge linkClk);
			#1;
			k++;
		end
		check({31'h0, rxLocked}, {31'h0, lv});
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset;
		rdc(CA, ctl(5'h15, 0, 0, 1, 0, 0));
		check({27'h0, phyAddr}, 32'h15);
		$display("test reset values done");
	endtask

	task automatic t_override;
		wrc(CA, 16'h87ed, 1'b0);
		rdc(CA, ctl(5'h15, 1, 1, 1, 1, 1));
		wrc(5'h03, 16'h0000, 1'b1);
		rdc(CA, ctl(5'h15, 0, 1, 1, 1, 1));
		wrc(5'h03, 16'h0000, 1'b0);
		$display("test override done");
	endtask

	task automatic t_resets;
		ledAddrPin <= 5'h0a;
		@(posedge ref_clk);
		swRst <= 1'b1;
		@(posedge ref_clk);
		swRst <= 1'b0;
		rdc(CA, ctl(5'h15, 0, 0, 1, 0, 0));
		rdc(5'h1f, 32'h0);
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge linkClk);
		rdc(CA, ctl(5'h0a, 0, 0, 1, 0, 0));
		check({27'h0, phyAddr}, 32'h0a);
		$display("test resets done");
	endtask

	task automatic t_map;
		wrc(CA, 16'h0004, 1'b0);
		for (int i = 0; i < 16; i++)
		begin
			send(i[3:0], 1'b1, INV_EXP[i]);
			send(i[3:0], 1'b0, pxc_pkg::STD_CODE[i]);
		end
		wrc(CA, 16'h0008, 1'b0);
		for (int i = 0; i < 16; i++)
			send(i[3:0], 1'b1, pxc_pkg::STD_CODE[i]);
		$display("test code maps done");
	endtask

	// four nibbles offered back to back: buffer refuses, then drains, nothing lost
	task automatic t_stall;
		int taken;
		int low;
		int zeros;
		taken = 0;
		low = 0;
		zeros = 0;
		@(posedge linkClk);
		txErr <= 1'b0;
		txNib <= 4'h0;
		nibValid <= 1'b1;
		for (int k = 0; k < 40; k++)
		begin
			#1;
			if (txSer === 1'b0)
				zeros++;
			if (nibValid === 1'b1 && nibReady === 1'b1)
				taken++;
			else if (nibValid === 1'b1)
				low++;
			@(posedge linkClk);
			if (taken == 4)
				nibValid <= 1'b0;
		end
		check(taken, 4);
		check({31'h0, low > 0}, 32'h1);
		check(zeros, 4);
		check({31'h0, nibReady}, 32'h1);
		$display("test stall done");
	endtask

	task automatic t_line;
		logic [23:0] h;
		@(posedge ref_clk);
		speed100 <= 1'b1;
		wrc(CA, 16'h0001, 1'b0);
		send(4'h5, 1'b0, pxc_pkg::STD_CODE[5]);
		wrc(CA, 16'h0009, 1'b0);
		grab(10, h);
		check({31'h0, h[9:0] === 10'h155 || h[9:0] === 10'h2aa}, 32'h1);
		wrc(CA, 16'h0000, 1'b0);
		grab(24, h);
		check({31'h0, h !== 24'hffffff}, 32'h1);
		$display("test line coding done");
	endtask

	task automatic t_lock;
		waitLock(1'b1, 400);
		check({31'h0, rxPlain}, 32'h1);
		wrc(CA, 16'h0020, 1'b0);
		waitLock(1'b0, 20);
		wrc(CA, 16'h0000, 1'b0);
		waitLock(1'b1, 400);
		$display("test lock done");
	endtask

	// ---------------------------------------------------------------
	// main sequence and watchdog
	// ---------------------------------------------------------------
	initial
	begin
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge linkClk);
		t_reset();
		t_override();
		t_resets();
		t_map();
		t_stall();
		t_line();
		t_lock();
		print_verdict();
	end

	initial
	begin
		#800000;
		check(32'h0, 32'h1);
		print_verdict();
	end
endmodule
